//--- bps_pkg.sv
package bps_pkg;

  // Line timing: bit time in ns at the jumper default rate, then cycles at the core clock
  localparam int unsigned CLK_MHZ   = 40;
  localparam int unsigned DEF_BAUD  = 1200;
  localparam int unsigned BIT_NS    = 1_000_000_000 / DEF_BAUD;
  localparam int unsigned BIT_CYC   = (BIT_NS * CLK_MHZ) / 1000;

  localparam int unsigned DEPTH     = 256;
  localparam int          AW        = 8;
  localparam int          CW        = 9;
  localparam int          TMR_W     = 18;

  localparam logic [7:0] CH_XON     = 8'h11;
  localparam logic [7:0] CH_XOFF    = 8'h13;

  localparam logic [3:0] BITS_MIN   = 4'h5;
  localparam logic [3:0] BITS_MAX   = 4'h8;
  localparam logic [1:0] PAR_NONE   = 2'h0;
  localparam logic [1:0] PAR_ODD    = 2'h1;
  localparam logic [1:0] PAR_EVEN   = 2'h2;
  localparam logic [1:0] STOP_1     = 2'h1;
  localparam logic [1:0] STOP_2     = 2'h2;
  localparam logic [1:0] STOP_1P5   = 2'h3;
  localparam logic [1:0] CLR_TX     = 2'h0;
  localparam logic [1:0] CLR_RX     = 2'h1;
  localparam logic [1:0] CLR_BOTH   = 2'h2;
  localparam logic       SEL_RX     = 1'b1;

  typedef struct packed {
    logic [3:0] bits;
    logic [1:0] parity;
    logic [1:0] stop;
    logic       sw_hs;
    logic       hw_hs;
  } bps_cfg_t;

  localparam bps_cfg_t CFG_DEF = '{bits: BITS_MAX, parity: PAR_NONE, stop: STOP_1, sw_hs: 1'b0, hw_hs: 1'b0};

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} bps_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} bps_rx_st_t;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [AW-1:0]         wp;
    logic [AW-1:0]         rp;
    logic [CW-1:0]         cnt;
  } bps_fifo_st_t;

  typedef struct packed {
    bps_cfg_t         cfg;
    bps_tx_st_t       tx_st;
    logic [TMR_W-1:0] tx_tmr;
    logic [2:0]       tx_idx;
    logic [7:0]       tx_sh;
    logic             tx_par;
    logic             txd;
    bps_rx_st_t       rx_st;
    logic [TMR_W-1:0] rx_tmr;
    logic [2:0]       rx_idx;
    logic [7:0]       rx_sh;
    logic             rx_par;
    logic             xoff;
    logic             ovr;
    logic             lerr;
    logic [7:0]       rd_data;
    logic [CW-1:0]    cnt;
    logic             tx_led;
    logic             rx_led;
  } bps_port_st_t;

  function automatic logic cfg_ok(input bps_cfg_t c);
    return (c.bits >= BITS_MIN) && (c.bits <= BITS_MAX) && (c.parity <= PAR_EVEN) && (c.stop != 2'h0);
  endfunction

  // Parity over the low c.bits bits only
  function automatic logic par_bit(input logic [7:0] d, input bps_cfg_t c);
    logic [7:0] m;
    m = d & 8'(8'hff >> (BITS_MAX - c.bits));
    return (c.parity == PAR_ODD) ? ~^m : ^m;
  endfunction

endpackage

//--- bps_fifo.sv
`timescale 1ns/100ps
module bps_fifo import bps_pkg::*; (
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          push_i,
  input  wire logic [7:0]    din_i,
  input  wire logic          pop_i,
  input  wire logic          clr_i,
  output logic      [7:0]    head_o,
  output logic      [CW-1:0] count_o,
  output logic               full_o,
  output logic               empty_o
);

  bps_fifo_st_t q;
  bps_fifo_st_t n;
  logic         push_ok;
  logic         pop_ok;

  assign empty_o = (q.cnt == '0);
  assign full_o  = (q.cnt == CW'(DEPTH));
  assign head_o  = q.mem[q.rp];
  assign count_o = q.cnt;
  // A full buffer drops the push; the caller decides what that means
  assign push_ok = push_i && !full_o;
  assign pop_ok  = pop_i && !empty_o;

  always_comb begin
    n = q;
    if (clr_i) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end else begin
      if (push_ok) begin
        n.mem[q.wp] = din_i;
        n.wp        = q.wp + AW'(1);
      end
      if (pop_ok) begin
        n.rp = q.rp + AW'(1);
      end
      n.cnt = q.cnt + CW'(push_ok) - CW'(pop_ok);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= n;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  fifo_keeps_a: assert property (ce_i && push_i && !full_o && !pop_i && !clr_i |=> q.cnt == $past(q.cnt) + 9'h001) // [RULE_02]
    else $error("accepted character not counted");

  fifo_order_a: assert property (ce_i && push_i && empty_o && !clr_i |=> head_o == $past(din_i)) // [RULE_10]
    else $error("first stored character not at head");

endmodule // bps_fifo

//--- bps_port.sv
// How it works
// RULE_01: Separate 256-character receive and transmit buffers.
// RULE_02: Receiver holds 256 characters without loss.
// RULE_03: Transmitter drains its buffer on its own.
// RULE_04: Data bits programmable five to eight.
// RULE_05: Parity code 0 none, 1 odd, 2 even.
// RULE_06: Stop code 1 one, 2 two, 3 one-and-half.
// RULE_07: Software and hardware handshakes each enable-selectable.
// RULE_08: Default 8N1, fixed start bit, handshakes off, 1200.
// RULE_09: Power-up clears handshakes and both buffers.
// RULE_10: Every received character stored, oldest read first.
// RULE_11: Read returns next character, zero when empty.
// RULE_12: Exact buffer character count is reported.
// RULE_13: Host purges receive buffer before collecting a block.
// RULE_14: Host keeps tape recorder rate at 2400 or less.
// RULE_15: Activity indicators lit while sending or receiving.
// RULE_16: Clear selector 0 transmit, 1 receive, 2 both.
// RULE_17: Count selector 1 receive, 0 transmit.
// RULE_18: XOFF pauses after current character, XON resumes.
// RULE_19: Hardware handshake starts characters only with DCD.
// RULE_20: Full receive buffer discards character, sets overrun.
`timescale 1ns/100ps
module bps_port import bps_pkg::*; #(
  parameter int unsigned BIT_CYC_P = BIT_CYC
) (
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          rxd_i,
  input  wire logic          dcd_i,
  output logic               txd_o,
  input  wire logic          cfg_wr_i,
  input  wire bps_cfg_t      cfg_i,
  output bps_cfg_t           cfg_o,
  input  wire logic          tx_wr_i,
  input  wire logic [7:0]    tx_data_i,
  input  wire logic          rx_rd_i,
  output logic      [7:0]    rx_data_o,
  input  wire logic          cnt_sel_i,
  output logic      [CW-1:0] cnt_o,
  input  wire logic          clr_i,
  input  wire logic [1:0]    clr_sel_i,
  input  wire logic          flag_clr_i,
  output logic               overrun_o,
  output logic               line_err_o,
  output logic               xoff_o,
  output logic               transmit_activity_led_o,
  output logic               receive_activity_led_o
);

  localparam logic [TMR_W-1:0] BIT_L  = TMR_W'(BIT_CYC_P);
  localparam logic [TMR_W-1:0] HALF_L = TMR_W'(BIT_CYC_P / 2);

  bps_port_st_t     q;
  bps_port_st_t     n;
  logic             tx_pop;
  logic             tx_clr;
  logic             rx_push;
  logic             rx_clr;
  logic [7:0]       rx_byte;
  logic [7:0]       tx_head;
  logic [7:0]       rx_head;
  logic [CW-1:0]    tx_cnt;
  logic [CW-1:0]    rx_cnt;
  logic             tx_empty;
  logic             rx_empty;
  logic             rx_full;
  logic             tx_end;
  logic             rx_end;
  logic             tx_last;
  logic             rx_last;
  logic [TMR_W-1:0] stop_len;

  assign tx_clr = clr_i && (clr_sel_i == CLR_TX || clr_sel_i == CLR_BOTH); // [RULE_16]
  assign rx_clr = clr_i && (clr_sel_i == CLR_RX || clr_sel_i == CLR_BOTH); // [RULE_16]

  // Host writes into a full transmit buffer are dropped
  bps_fifo u_tx_buf ( // [RULE_01]
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .push_i     (tx_wr_i),
    .din_i      (tx_data_i),
    .pop_i      (tx_pop),
    .clr_i      (tx_clr),
    .head_o     (tx_head),
    .count_o    (tx_cnt),
    .full_o     (),
    .empty_o    (tx_empty)
  );

  bps_fifo u_rx_buf ( // [RULE_01]
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .push_i     (rx_push),
    .din_i      (rx_byte),
    .pop_i      (rx_rd_i),
    .clr_i      (rx_clr),
    .head_o     (rx_head),
    .count_o    (rx_cnt),
    .full_o     (rx_full),
    .empty_o    (rx_empty)
  );

  assign tx_end  = (q.tx_tmr == TMR_W'(1));
  assign rx_end  = (q.rx_tmr == TMR_W'(1));
  assign tx_last = ({1'b0, q.tx_idx} + 4'h1 == q.cfg.bits); // [RULE_04]
  assign rx_last = ({1'b0, q.rx_idx} + 4'h1 == q.cfg.bits); // [RULE_04]

  always_comb begin
    case (q.cfg.stop) // [RULE_06]
      STOP_2:   stop_len = BIT_L + BIT_L;
      STOP_1P5: stop_len = BIT_L + HALF_L;
      default:  stop_len = BIT_L;
    endcase
  end

  always_comb begin
    n       = q;
    tx_pop  = 1'b0;
    rx_push = 1'b0;
    rx_byte = q.rx_sh >> (BITS_MAX - q.cfg.bits);

    // Malformed settings are ignored so the line never runs with an undefined frame
    if (cfg_wr_i && cfg_ok(cfg_i)) begin // [RULE_04] [RULE_05] [RULE_06] [RULE_07]
      n.cfg = cfg_i;
    end

    if (q.tx_st != TX_IDLE && !tx_end) begin
      n.tx_tmr = q.tx_tmr - TMR_W'(1);
    end
    case (q.tx_st)
      TX_IDLE: begin
        // Handshakes only gate a new character; one in flight always completes
        if (!tx_empty && !q.xoff && (!q.cfg.hw_hs || dcd_i)) begin // [RULE_03] [RULE_18] [RULE_19]
          tx_pop   = 1'b1;
          n.tx_sh  = tx_head;
          n.tx_par = par_bit(tx_head, q.cfg); // [RULE_05]
          n.txd    = 1'b0; // [RULE_08]
          n.tx_tmr = BIT_L;
          n.tx_st  = TX_START;
        end
      end
      TX_START: begin
        if (tx_end) begin
          n.tx_st  = TX_DATA;
          n.txd    = q.tx_sh[0];
          n.tx_idx = '0;
          n.tx_tmr = BIT_L;
        end
      end
      TX_DATA: begin
        if (tx_end) begin
          n.tx_tmr = BIT_L;
          if (tx_last && q.cfg.parity == PAR_NONE) begin // [RULE_05]
            n.tx_st  = TX_STOP;
            n.txd    = 1'b1;
            n.tx_tmr = stop_len;
          end else if (tx_last) begin
            n.tx_st = TX_PAR;
            n.txd   = q.tx_par;
          end else begin
            n.tx_idx = q.tx_idx + 3'h1;
            n.tx_sh  = q.tx_sh >> 1;
            n.txd    = q.tx_sh[1];
          end
        end
      end
      TX_PAR: begin
        if (tx_end) begin
          n.tx_st  = TX_STOP;
          n.txd    = 1'b1;
          n.tx_tmr = stop_len; // [RULE_06]
        end
      end
      TX_STOP: begin
        if (tx_end) begin
          n.tx_st = TX_IDLE;
        end
      end
      default: begin
        n.tx_st = TX_IDLE;
        n.txd   = 1'b1;
      end
    endcase

    if (q.rx_st != RX_IDLE && !rx_end) begin
      n.rx_tmr = q.rx_tmr - TMR_W'(1);
    end
    case (q.rx_st)
      RX_IDLE: begin
        if (!rxd_i) begin
          n.rx_st  = RX_START;
          n.rx_tmr = HALF_L;
        end
      end
      RX_START: begin
        // Mid-bit recheck rejects glitches shorter than half a bit
        if (rx_end) begin
          n.rx_st  = rxd_i ? RX_IDLE : RX_DATA;
          n.rx_idx = '0;
          n.rx_tmr = BIT_L;
        end
      end
      RX_DATA: begin
        if (rx_end) begin
          n.rx_sh  = {rxd_i, q.rx_sh[7:1]};
          n.rx_tmr = BIT_L;
          n.rx_idx = q.rx_idx + 3'h1;
          if (rx_last) begin
            n.rx_st = (q.cfg.parity == PAR_NONE) ? RX_STOP : RX_PAR; // [RULE_05]
          end
        end
      end
      RX_PAR: begin
        if (rx_end) begin
          n.rx_par = rxd_i;
          n.rx_st  = RX_STOP;
          n.rx_tmr = BIT_L;
        end
      end
      RX_STOP: begin
        // Only the first stop bit is checked, so any stop setting receives
        if (rx_end) begin
          n.rx_st = RX_IDLE;
          rx_push = 1'b1; // [RULE_10]
          if (!rxd_i || (q.cfg.parity != PAR_NONE && q.rx_par != par_bit(rx_byte, q.cfg))) begin
            n.lerr = 1'b1;
          end
          if (rx_full) begin
            n.ovr = 1'b1; // [RULE_20]
          end
          if (q.cfg.sw_hs && rx_byte == CH_XOFF) begin
            n.xoff = 1'b1; // [RULE_18]
          end
          if (q.cfg.sw_hs && rx_byte == CH_XON) begin
            n.xoff = 1'b0; // [RULE_18]
          end
        end
      end
      default: begin
        n.rx_st = RX_IDLE;
      end
    endcase

    if (!n.cfg.sw_hs) begin
      n.xoff = 1'b0;
    end
    // Clear first so a same-cycle event still sets its flag
    if (flag_clr_i) begin
      n.ovr  = rx_push && rx_full; // [RULE_20]
      n.lerr = 1'b0;
      if (rx_push && (!rxd_i || (q.cfg.parity != PAR_NONE && q.rx_par != par_bit(rx_byte, q.cfg)))) begin
        n.lerr = 1'b1;
      end
    end

    if (rx_rd_i) begin
      n.rd_data = rx_empty ? 8'h00 : rx_head; // [RULE_10] [RULE_11]
    end
    n.cnt    = (cnt_sel_i == SEL_RX) ? rx_cnt : tx_cnt; // [RULE_12] [RULE_17]
    n.tx_led = (n.tx_st != TX_IDLE); // [RULE_15]
    n.rx_led = (n.rx_st != RX_IDLE); // [RULE_15]
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q     <= '0;
      q.cfg <= CFG_DEF; // [RULE_08] [RULE_09]
      q.txd <= 1'b1;
    end else if (ce_i) begin
      q <= n;
    end
  end

  assign txd_o                   = q.txd;
  assign cfg_o                   = q.cfg;
  assign rx_data_o               = q.rd_data;
  assign cnt_o                   = q.cnt;
  assign overrun_o               = q.ovr;
  assign line_err_o              = q.lerr;
  assign xoff_o                  = q.xoff;
  assign transmit_activity_led_o = q.tx_led;
  assign receive_activity_led_o  = q.rx_led;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  read_empty_a: assert property (ce_i && rx_rd_i && rx_empty |=> rx_data_o == 8'h00) // [RULE_11]
    else $error("empty receive read did not return zero");

  read_head_a: assert property (ce_i && rx_rd_i && !rx_empty |=> rx_data_o == $past(rx_head)) // [RULE_10]
    else $error("receive read did not return oldest character");

  rx_overrun_a: assert property (ce_i && rx_push && rx_full && !rx_clr
                                 |=> overrun_o && rx_cnt == $past(rx_cnt) - CW'($past(rx_rd_i))) // [RULE_20]
    else $error("overrun not flagged or character kept");

  xoff_hold_a: assert property (ce_i && q.tx_st == TX_IDLE && q.xoff |=> q.tx_st == TX_IDLE) // [RULE_18]
    else $error("transmitter started while paused");

  dcd_gate_a: assert property (ce_i && q.tx_st == TX_IDLE && q.cfg.hw_hs && !dcd_i |=> q.tx_st == TX_IDLE) // [RULE_19]
    else $error("transmitter started without carrier");

  start_bit_a: assert property (q.tx_st == TX_START |-> !txd_o && transmit_activity_led_o) // [RULE_08] [RULE_15]
    else $error("start bit or activity indicator wrong");

  auto_send_a: assert property (ce_i && q.tx_st == TX_IDLE && !tx_empty && !q.xoff && !q.cfg.hw_hs && !tx_clr ##1 ce_i
                                |-> q.tx_st == TX_START
                                    && tx_cnt == $past(tx_cnt) - 9'h001
                                       + CW'($past(tx_wr_i) && $past(tx_cnt) != CW'(DEPTH))) // [RULE_03]
    else $error("queued character not sent");

  cfg_reject_a: assert property (ce_i && cfg_wr_i && !cfg_ok(cfg_i) |=> cfg_o == $past(cfg_o)) // [RULE_04]
    else $error("invalid setting accepted");

  clr_both_a: assert property (ce_i && clr_i && clr_sel_i == CLR_BOTH |=> rx_cnt == '0 && tx_cnt == '0) // [RULE_16]
    else $error("clear both left characters");

  count_sel_a: assert property (ce_i && cnt_sel_i == SEL_RX |=> cnt_o == $past(rx_cnt)) // [RULE_17] [RULE_12]
    else $error("receive count not reported");

endmodule // bps_port

//--- bps_dev.sv
`timescale 1ns/100ps
module bps_dev import bps_pkg::*; #(
  parameter int unsigned BIT_P = 16
) (
  input  wire logic       core_clk_i,
  input  wire logic       txd_i,
  input  wire bps_cfg_t   cfg_i,
  output logic            rxd_o,
  output logic            got_o,
  output logic      [7:0] byte_o,
  output logic            perr_o
);
  logic [7:0] sh;

  initial begin
    rxd_o  = 1'b1;
    got_o  = 1'b0;
    byte_o = 8'h00;
    perr_o = 1'b0;
  end

  // Kept apart from the design's own parity helper so a shared slip cannot hide
  function automatic logic par_of(input logic [7:0] d, input logic [1:0] p);
    return (p == PAR_ODD) ? ~^d : ^d;
  endfunction

  task automatic send(input logic [7:0] d);
    int n;
    n = (cfg_i.stop == STOP_2) ? 2 * BIT_P : (cfg_i.stop == STOP_1P5) ? BIT_P + BIT_P / 2 : BIT_P;
    d = d & 8'(8'hff >> (8 - cfg_i.bits));
    @(posedge core_clk_i) rxd_o <= 1'b0;
    repeat (BIT_P) @(posedge core_clk_i);
    for (int i = 0; i < cfg_i.bits; i++) begin
      rxd_o <= d[i];
      repeat (BIT_P) @(posedge core_clk_i);
    end
    if (cfg_i.parity != PAR_NONE) begin
      rxd_o <= par_of(d, cfg_i.parity);
      repeat (BIT_P) @(posedge core_clk_i);
    end
    rxd_o <= 1'b1;
    repeat (n) @(posedge core_clk_i);
  endtask

  // Samples each frame from the port at mid-bit
  always begin
    @(negedge txd_i);
    repeat (BIT_P / 2) @(posedge core_clk_i);
    sh = 8'h00;
    for (int i = 0; i < cfg_i.bits; i++) begin
      repeat (BIT_P) @(posedge core_clk_i);
      sh[i] = txd_i;
    end
    perr_o <= 1'b0;
    if (cfg_i.parity != PAR_NONE) begin
      repeat (BIT_P) @(posedge core_clk_i);
      perr_o <= (txd_i !== par_of(sh, cfg_i.parity));
    end
    repeat (BIT_P) @(posedge core_clk_i);
    if (txd_i !== 1'b1) begin
      perr_o <= 1'b1;
    end
    byte_o <= sh;
    got_o  <= 1'b1;
    @(posedge core_clk_i) got_o <= 1'b0;
  end
endmodule // bps_dev

//--- bps_port_test.sv
`timescale 1ns/100ps
module bps_port_test import bps_pkg::*;;
  // Short bit time keeps the run short; the far side is no tape recorder, so no tape rate cap
  localparam int unsigned BP = 16;
  logic            core_clk_i = 1'b0;
  logic            rst_i = 1'b1;
  logic            ce_i = 1'b1;
  logic            rxd, dcd_i, txd_o, cfg_wr_i, tx_wr_i, rx_rd_i, cnt_sel_i, clr_i, flag_clr_i;
  logic            overrun_o, line_err_o, xoff_o, transmit_activity_led_o, receive_activity_led_o;
  bps_cfg_t        cfg_i, cfg_o, nc;
  logic      [7:0] tx_data_i, rx_data_o, dev_byte, seed, first;
  logic      [1:0] clr_sel_i;
  logic   [CW-1:0] cnt_o;
  logic            got, perr, rd_seen;
  int              miscompares = 0;
  int              num_checks = 0;
  logic      [7:0] rq[$];
  logic      [7:0] tq[$];

  always #12.5 core_clk_i = ~core_clk_i;

  bps_port #(.BIT_CYC_P(BP)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .rxd_i(rxd),
    .dcd_i(dcd_i), .txd_o(txd_o), .cfg_wr_i(cfg_wr_i), .cfg_i(cfg_i), .cfg_o(cfg_o), .tx_wr_i(tx_wr_i),
    .tx_data_i(tx_data_i), .rx_rd_i(rx_rd_i), .rx_data_o(rx_data_o), .cnt_sel_i(cnt_sel_i), .cnt_o(cnt_o),
    .clr_i(clr_i), .clr_sel_i(clr_sel_i), .flag_clr_i(flag_clr_i), .overrun_o(overrun_o),
    .line_err_o(line_err_o), .xoff_o(xoff_o), .transmit_activity_led_o(transmit_activity_led_o),
    .receive_activity_led_o(receive_activity_led_o));

  bps_dev #(.BIT_P(BP)) dev (.core_clk_i(core_clk_i), .txd_i(txd_o), .cfg_i(cfg_i), .rxd_o(rxd),
    .got_o(got), .byte_o(dev_byte), .perr_o(perr));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk_c(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: char got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_f(input logic [9:0] g, input logic [9:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: value got %h expected %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  // One host strobe: 0 write, 1 read, 2 clear, 3 config, 4 flag clear
  task automatic op(input int k, input logic [7:0] d);
    @(posedge core_clk_i);
    case (k)
      0: begin
        tx_wr_i   <= 1'b1;
        tx_data_i <= d;
      end
      1: begin
        rx_rd_i <= 1'b1;
        rq.push_back(d);
      end
      2: begin
        clr_i     <= 1'b1;
        clr_sel_i <= d[1:0];
      end
      3: begin
        cfg_wr_i <= 1'b1;
        cfg_i    <= nc;
      end
      default: flag_clr_i <= 1'b1;
    endcase
    @(posedge core_clk_i);
    {tx_wr_i, rx_rd_i, clr_i, cfg_wr_i, flag_clr_i} <= 5'h00;
  endtask

  task automatic cnt(input logic s, input logic [9:0] e);
    @(posedge core_clk_i) cnt_sel_i <= s;
    repeat (3) @(posedge core_clk_i);
    #1 chk_f(cnt_o, e);
  endtask

  task automatic drain();
    @(posedge core_clk_i) cnt_sel_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    for (int i = 0; i < 8000 && (cnt_o !== 9'h000 || transmit_activity_led_o !== 1'b0); i++) begin
      @(posedge core_clk_i);
    end
    #1 chk_f(transmit_activity_led_o, 10'h000);
  endtask

  // Results land here, oldest note first
  always @(posedge core_clk_i) begin
    if (rd_seen === 1'b1) begin
      chk_c(rx_data_o, rq.pop_front());
    end
    rd_seen <= rx_rd_i;
    if (got === 1'b1) begin
      chk_c(dev_byte, tq.pop_front());
      chk_f(perr, 10'h000);
    end
  end

  initial begin
    // About 80k cycles: the 257-character overrun burst dominates at under 42k
    #2_000_000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    {dcd_i, cfg_wr_i, tx_wr_i, rx_rd_i, cnt_sel_i, clr_i, flag_clr_i, rd_seen} = 8'h00;
    tx_data_i = 8'h00;
    clr_sel_i = 2'h3;
    cfg_i     = CFG_DEF;
    seed      = 8'h0e;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1 chk_f(cfg_o, CFG_DEF);
    chk_f(txd_o, 10'h001);
    cnt(1'b1, 10'h000);
    cnt(1'b0, 10'h000);
    op(1, 8'h00);
    tend("reset");
    nc = CFG_DEF;
    nc.hw_hs = 1'b1;
    op(3, 8'h00);
    op(0, 8'h5a);
    op(0, 8'ha5);
    repeat (60) @(posedge core_clk_i);
    cnt(1'b0, 10'h002);
    op(2, CLR_TX);
    cnt(1'b0, 10'h000);
    @(posedge core_clk_i) dcd_i <= 1'b1;
    tend("carrier");
    for (int m = 0; m < 4; m++) begin
      nc = '{bits: 4'(5 + m), parity: 2'(m % 3), stop: 2'(1 + m % 3), sw_hs: 1'b0, hw_hs: 1'b1};
      op(3, 8'h00);
      #1 chk_f(cfg_o, nc);
      for (int j = 0; j < 3; j++) begin
        seed = lfsr(seed);
        tq.push_back(seed & 8'(8'hff >> (3 - m)));
        op(0, seed);
      end
      #1 chk_f(transmit_activity_led_o, 10'h001);
      drain();
    end
    tend("framing");
    nc = CFG_DEF;
    op(3, 8'h00);
    op(2, CLR_RX); // Purge before a new block
    fork
      dev.send(8'h00);
      begin
        repeat (40) @(posedge core_clk_i);
        #1 chk_f(receive_activity_led_o, 10'h001);
      end
    join
    dev.send(8'h41);
    dev.send(8'hc3);
    cnt(1'b1, 10'h003);
    op(1, 8'h00);
    op(1, 8'h41);
    op(1, 8'hc3);
    op(1, 8'h00);
    cnt(1'b1, 10'h000);
    tend("receive");
    nc.hw_hs = 1'b1;
    op(3, 8'h00);
    @(posedge core_clk_i) dcd_i <= 1'b0;
    op(0, 8'h77);
    dev.send(8'h12);
    cnt(1'b0, 10'h001);
    op(2, CLR_BOTH);
    cnt(1'b0, 10'h000);
    cnt(1'b1, 10'h000);
    dev.send(8'h34);
    op(2, CLR_RX);
    cnt(1'b1, 10'h000);
    @(posedge core_clk_i) dcd_i <= 1'b1;
    tend("clear");
    nc = CFG_DEF;
    nc.sw_hs = 1'b1;
    op(3, 8'h00);
    dev.send(CH_XOFF);
    #1 chk_f(xoff_o, 10'h001);
    op(0, 8'h3c);
    repeat (100) @(posedge core_clk_i);
    cnt(1'b0, 10'h001);
    tq.push_back(8'h3c);
    dev.send(CH_XON);
    drain();
    chk_f(xoff_o, 10'h000);
    op(2, CLR_RX);
    tend("xon_xoff");
    nc = CFG_DEF;
    op(3, 8'h00);
    first = 8'h00;
    for (int i = 0; i < 257; i++) begin
      seed = lfsr(seed);
      if (i == 0) begin
        first = seed;
      end
      dev.send(seed);
    end
    cnt(1'b1, 10'h100);
    chk_f(overrun_o, 10'h001);
    op(4, 8'h00);
    #1 chk_f(overrun_o, 10'h000);
    op(1, first);
    chk_f(line_err_o, 10'h000);
    tend("overrun");
    @(posedge core_clk_i) ce_i <= 1'b0;
    op(2, CLR_RX); // Dropped while frozen
    @(posedge core_clk_i) ce_i <= 1'b1;
    cnt(1'b1, 10'h0ff);
    op(2, 8'h03); // Selector 3 names no buffer
    cnt(1'b1, 10'h0ff);
    op(2, CLR_RX);
    nc.parity = PAR_EVEN;
    op(3, 8'h00);
    // Far side alone switches to odd parity, so the port sees a bad parity bit
    @(posedge core_clk_i) cfg_i.parity <= PAR_ODD;
    dev.send(8'h5a);
    #1 chk_f(line_err_o, 10'h001);
    cnt(1'b1, 10'h001);
    tend("freeze_parity");
    repeat (4) @(posedge core_clk_i);
    report_and_stop();
  end
endmodule // bps_port_test
